//--- hdl/windowed_watchdog_timer.v
// Windowed watchdog with long, closed, open and short open windows.
//
// Decided for this implementation: strobed register access.
`include "wdt_map.vh"

module windowed_watchdog_timer
#(
	parameter [15:0] LP_TICKS_PER_MS = `LP_TICKS_PER_MS_DEF
)
(
	input  wire        mclk,
	input  wire        rst,
	input  wire [7:0]  addr,
	input  wire [31:0] wdata,
	input  wire        wr,
	input  wire        rd,
	output reg  [31:0] rdata,
	input  wire        active_mode,
	input  wire        debug_mode,
	input  wire        low_power_clock,
	output reg         reset_req,
	output reg         sleep_req,
	output reg         watchdog_reset_flag,
	output reg         wdt_running
);

	// Window states; OFF covers every mode in which supervision rests.
	// The state code is shown in bits 7:5 of the status word.
	localparam [2:0] ST_OFF    = 3'h0;
	localparam [2:0] ST_LONG   = 3'h1;
	localparam [2:0] ST_CLOSED = 3'h2;
	localparam [2:0] ST_OPEN   = 3'h3;
	localparam [2:0] ST_SOW    = 3'h4;

	// Registered window state, countdown, open length, short window counter and fault counter.
	reg  [2:0]  state_r;
	reg  [2:0]  state_nxt;
	reg  [23:0] timer_r;
	reg  [23:0] timer_nxt;
	reg  [23:0] open_r;
	reg  [23:0] open_nxt;
	reg  [1:0]  sow_cnt_r;
	reg  [1:0]  sow_cnt_nxt;
	reg  [2:0]  miss_r;
	reg  [2:0]  miss_nxt;
	reg  [7:0]  trig_r;
	reg         en_r;
	reg         fault;
	reg         reset_nxt;
	reg         sleep_nxt;

	// Decoded bus strobes, incremented counters and window lengths.
	wire        lp_tick;
	wire        enabled;
	wire        enable_rise;
	wire        trig_wr;
	wire        cause_wr;
	wire [5:0]  wr_code;
	wire [1:0]  wr_conf;
	wire [2:0]  sow_plus;
	wire [2:0]  miss_plus;
	wire [31:0] long_full;
	wire [31:0] sow_full;
	wire [31:0] step_full;
	wire [31:0] per_full;
	wire [23:0] long_ticks;
	wire [23:0] sow_ticks;
	wire [23:0] per_ticks;
	wire [23:0] closed_ticks;
	wire        expire;

	// Low-power edges are counted in the mclk domain through three flops.
	// A stalled mclk therefore stalls supervision as well.
	lp_tick_sync u_lp_tick_sync // R2
	(
		.mclk      (mclk),
		.rst       (rst),
		.lp_clk_in (low_power_clock),
		.lp_tick   (lp_tick)
	);

	// Window lengths in low-power clock edges.
	// Products stay 32 bits wide and are cut to the 24-bit timer on purpose.
	assign long_full    = `LONG_WIN_MS * {16'h0000, LP_TICKS_PER_MS}; // R4
	assign sow_full     = `SOW_WIN_MS * {16'h0000, LP_TICKS_PER_MS}; // R13
	assign step_full    = `PERIOD_STEP_MS * {16'h0000, LP_TICKS_PER_MS};
	assign per_full     = {26'h0000000, wr_code} * step_full; // R6
	assign long_ticks   = long_full[23:0];
	assign sow_ticks    = sow_full[23:0];
	assign per_ticks    = per_full[23:0];
	assign closed_ticks = {1'b0, per_ticks[23:1]}; // R8

	// Only Active Mode outside debug lets the watchdog run; no disable bit.
	// Debug parks the watchdog in OFF so that a breakpoint never ends in a reset.
	assign enabled     = active_mode && !debug_mode; // R1
	assign enable_rise = enabled && !en_r;

	// Byte-addressed decode; only the low byte of the trigger is stored.
	// The upper three bytes of a trigger write carry no fields.
	assign trig_wr   = wr && (addr == `TRIG_OFS); // R17
	assign cause_wr  = wr && (addr == `CAUSE_OFS);
	assign wr_code   = wdata[`PSEL_MSB:`PSEL_LSB];
	assign wr_conf   = wdata[`SCONF_MSB:`SCONF_LSB]; // R14
	assign sow_plus  = {1'b0, sow_cnt_r} + 3'h1;
	assign miss_plus = miss_r + 3'h1;
	assign expire    = lp_tick && (timer_r <= 24'h000001);

	// Window sequencing; a trigger in the same cycle as a tick wins.
	// A tick lasts one mclk cycle, so each low-power edge counts once.
	always @*
	begin
		state_nxt   = state_r;
		timer_nxt   = timer_r;
		open_nxt    = open_r;
		sow_cnt_nxt = sow_cnt_r;
		miss_nxt    = miss_r;
		fault       = 1'b0;
		reset_nxt   = 1'b0;
		sleep_nxt   = 1'b0;
		// Leaving Active Mode parks the watchdog without counting a fault.
		if (!enabled)
		begin
			state_nxt = ST_OFF; // R1
		end
		else if (state_r == ST_OFF)
		begin
			if (enable_rise)
			begin
				state_nxt   = ST_LONG; // R3
				timer_nxt   = long_ticks; // R4
				sow_cnt_nxt = 2'h0;
				miss_nxt    = 3'h0; // R19
			end
		end
		else if (trig_wr)
		begin
			// A trigger decides in its own write cycle, ahead of any tick.
			if (wr_code == `SOW_CODE)
			begin
				if (state_r == ST_LONG)
				begin
					fault = 1'b1; // R12
				end
				else if (sow_plus > {1'b0, wr_conf})
				begin
					fault = 1'b1; // R15
				end
				else
				begin
					state_nxt   = ST_SOW; // R13
					timer_nxt   = sow_ticks;
					sow_cnt_nxt = sow_plus[1:0]; // R15
				end
			end
			else if (state_r == ST_CLOSED)
			begin
				fault = 1'b1; // R9
			end
			else
			begin
				// The new period starts in the write cycle itself.
				state_nxt   = ST_CLOSED; // R5 R7
				timer_nxt   = closed_ticks; // R8
				open_nxt    = per_ticks - closed_ticks;
				sow_cnt_nxt = 2'h0; // R16
				miss_nxt    = 3'h0; // R19
			end
		end
		else if (expire)
		begin
			// Running out anywhere but the closed half is a missed service.
			if (state_r == ST_CLOSED)
			begin
				state_nxt = ST_OPEN; // R8
				timer_nxt = open_r;
			end
			else
			begin
				fault = 1'b1; // R4 R9
			end
		end
		else if (lp_tick)
		begin
			timer_nxt = timer_r - 24'h000001;
		end

		// Repeated failures end in Sleep Mode rather than a reset storm.
		// Every kind of fault counts toward the same limit.
		if (fault)
		begin
			if (miss_plus == `MISS_LIMIT)
			begin
				sleep_nxt = 1'b1; // R11
				state_nxt = ST_OFF;
				miss_nxt  = 3'h0;
			end
			else
			begin
				reset_nxt   = 1'b1; // R9
				miss_nxt    = miss_plus;
				state_nxt   = ST_LONG; // R3
				timer_nxt   = long_ticks;
			end
			sow_cnt_nxt = 2'h0;
		end
	end

	// State, counters and one-cycle request pulses.
	// The running flag follows the next state, aligned with the pulses.
	always @(posedge mclk or posedge rst)
	begin
		if (rst)
		begin
			state_r     <= ST_OFF;
			timer_r     <= 24'h000000;
			open_r      <= 24'h000000;
			sow_cnt_r   <= 2'h0;
			miss_r      <= 3'h0;
			en_r        <= 1'b0;
			reset_req   <= 1'b0;
			sleep_req   <= 1'b0;
			wdt_running <= 1'b0;
		end
		else
		begin
			state_r     <= state_nxt;
			timer_r     <= timer_nxt;
			open_r      <= open_nxt;
			sow_cnt_r   <= sow_cnt_nxt;
			miss_r      <= miss_nxt;
			en_r        <= enabled;
			reset_req   <= reset_nxt; // R20
			sleep_req   <= sleep_nxt; // R20
			wdt_running <= (state_nxt != ST_OFF);
		end
	end

	// Trigger register keeps the last written code and configuration.
	// A write while the watchdog rests still updates the stored byte.
	always @(posedge mclk or posedge rst)
	begin
		if (rst)
		begin
			trig_r <= `TRIG_RESET;
		end
		else if (trig_wr)
		begin
			trig_r <= wdata[7:0];
		end
	end

	// Reset cause flag: write one clears, a new watchdog reset wins.
	// Letting the set win means a fault is never lost to a late clear.
	always @(posedge mclk or posedge rst)
	begin
		if (rst)
		begin
			watchdog_reset_flag <= 1'b0;
		end
		else if (reset_nxt)
		begin
			watchdog_reset_flag <= 1'b1; // R10
		end
		else if (cause_wr && wdata[`CAUSE_WDT_BIT])
		begin
			watchdog_reset_flag <= 1'b0;
		end
	end

	// Read data appears in the cycle after the read strobe only.
	// Unmapped reads and idle cycles give zero, so stale data never shows.
	always @(posedge mclk or posedge rst)
	begin
		if (rst)
		begin
			rdata <= 32'h00000000;
		end
		else if (rd)
		begin
			case (addr)
				`TRIG_OFS:
				begin
					rdata <= {24'h000000, trig_r}; // R17
				end
				`CAUSE_OFS:
				begin
					rdata <= {31'h00000000, watchdog_reset_flag};
				end
				`STAT_OFS:
				begin
					rdata <= {24'h000000, state_r, sow_cnt_r, miss_r};
				end
				default:
				begin
					rdata <= 32'h00000000;
				end
			endcase
		end
		else
		begin
			rdata <= 32'h00000000;
		end
	end

endmodule

//--- hdl/wdt_map.vh
// Offsets, field positions, reset values and timing figures of the watchdog.
//
// Notes on behaviour
// R1: Watchdog runs whenever Active Mode is on; off in Sleep, Stop, Debug.
// R2: Timebase counts edges of an independent low-power clock, not mclk.
// R3: Every entry into Active Mode restarts the watchdog in long open window.
// R4: Long open window lasts 200 ms; no trigger by its end causes reset.
// R5: A trigger write selects the next period and starts it at once.
// R6: Period select 1..63 gives a period of value times 16 ms.
// R7: After the first good trigger the watchdog runs in windowed mode.
// R8: First half of each period is closed, second half is open.
// R9: Trigger in closed half, or no trigger before expiry, requests reset.
// R10: A watchdog reset sets the watchdog reset flag in the cause register.
// R11: Five faults in a row force Sleep Mode instead of another reset.
// R12: Short window request during long open window causes reset.
// R13: Code 00 abandons the period and starts a fixed 30 ms short window.
// R14: Short window config 0 disables, 1 to 3 give the allowed maximum.
// R15: Each short trigger counts up; exceeding the maximum causes reset.
// R16: A trigger with nonzero period code clears the short window counter.
// R17: Trigger register at byte offset 34h; bits 31:8 read as zero.
// R18: Software should trigger well inside the open half of each period.
// R19: Fault counter clears on a good trigger and on entry to Active Mode.
// R20: Reset and sleep requests are one-cycle pulses on the mclk domain.
`ifndef WDT_MAP_VH
`define WDT_MAP_VH

// Register byte offsets.
`define TRIG_OFS       8'h34
`define CAUSE_OFS      8'h38
`define STAT_OFS       8'h3c

// Trigger register fields.
`define PSEL_MSB       5
`define PSEL_LSB       0
`define SCONF_MSB      7
`define SCONF_LSB      6
`define TRIG_RESET     8'h00
`define SOW_CODE       6'h00

// Reset cause register fields.
`define CAUSE_WDT_BIT  0

// Timing figures in milliseconds and fault limit.
`define LONG_WIN_MS    32'h000000c8
`define SOW_WIN_MS     32'h0000001e
`define PERIOD_STEP_MS 32'h00000010
`define MISS_LIMIT     3'h5

// Default low-power clock edges per millisecond.
`define LP_TICKS_PER_MS_DEF 16'h0020

`endif

//--- hdl/lp_tick_sync.v
// Brings the low-power clock into mclk and marks each of its rising edges.
module lp_tick_sync
(
	input  wire mclk,
	input  wire rst,
	input  wire lp_clk_in,
	output reg  lp_tick
);

	reg s1_r;
	reg s2_r;
	reg s3_r;
	reg level_r;

	// Three stages; a new level counts only once stages two and three agree.
	always @(posedge mclk or posedge rst)
	begin
		if (rst)
		begin
			s1_r    <= 1'b0;
			s2_r    <= 1'b0;
			s3_r    <= 1'b0;
			level_r <= 1'b0;
			lp_tick <= 1'b0;
		end
		else
		begin
			s1_r <= lp_clk_in;
			s2_r <= s1_r;
			s3_r <= s2_r;
			if (s2_r == s3_r)
			begin
				level_r <= s3_r;
			end
			lp_tick <= (s2_r == s3_r) && s3_r && !level_r;
		end
	end

endmodule

//--- testbench/wdt_props.sv
// Port-level checker for the windowed watchdog.
module wdt_props
(
	input wire logic        mclk,
	input wire logic        rst,
	input wire logic        rd,
	input wire logic [31:0] rdata,
	input wire logic        active_mode,
	input wire logic        debug_mode,
	input wire logic        reset_req,
	input wire logic        sleep_req,
	input wire logic        watchdog_reset_flag,
	input wire logic        wdt_running
);
	timeunit 1ns;
	timeprecision 1ps;

	// All checks live in the single mclk domain.
	default clocking cb @(posedge mclk); endclocking
	default disable iff (rst);

	// A read strobe followed by the cycle that carries its answer.
	sequence s_rd;
		rd ##1 1'b1;
	endsequence

	property p_pulse_r; reset_req |=> !reset_req; endproperty
	a_pulse_r: assert property (p_pulse_r)
		else $error("reset request longer than one cycle");
	property p_pulse_s; sleep_req |=> !sleep_req; endproperty
	a_pulse_s: assert property (p_pulse_s)
		else $error("sleep request longer than one cycle");
	property p_flag; reset_req |-> watchdog_reset_flag; endproperty
	a_flag: assert property (p_flag)
		else $error("reset request without cause flag");
	property p_excl; !(reset_req && sleep_req); endproperty
	a_excl: assert property (p_excl)
		else $error("reset and sleep requested together");
	property p_rdz; !$past(rd) |-> rdata == 32'h0; endproperty
	a_rdz: assert property (p_rdz)
		else $error("read data outside answer cycle");
	property p_rdhi; s_rd |-> rdata[31:8] == 24'h0; endproperty
	a_rdhi: assert property (p_rdhi)
		else $error("upper read bits not zero");
	property p_wake;
		$rose(active_mode) && !debug_mode |=> wdt_running;
	endproperty
	a_wake: assert property (p_wake)
		else $error("watchdog not started on active entry");
	property p_dbg; debug_mode [*3] |-> !wdt_running; endproperty
	a_dbg: assert property (p_dbg)
		else $error("watchdog running in debug");
	property p_sleepoff; sleep_req |-> ##2 !wdt_running; endproperty
	a_sleepoff: assert property (p_sleepoff)
		else $error("watchdog still running after sleep");
endmodule

bind windowed_watchdog_timer wdt_props chk_u
(
	.mclk               (mclk),
	.rst                (rst),
	.rd                 (rd),
	.rdata              (rdata),
	.active_mode        (active_mode),
	.debug_mode         (debug_mode),
	.reset_req          (reset_req),
	.sleep_req          (sleep_req),
	.watchdog_reset_flag(watchdog_reset_flag),
	.wdt_running        (wdt_running)
);

//--- testbench/tb.sv
// Self-checking bench for the windowed watchdog.
module tb;
	timeunit 1ns;
	timeprecision 1ps;

	logic        mclk = 0, rst = 1, wr = 0, rd = 0, lpc = 0;
	logic        act = 1, dbg = 0;
	logic [7:0]  addr = 8'h00;
	logic [31:0] wdata = 32'h0, rdata;
	logic        rreq, sreq, flag, run;
	int          err_count = 0, samples_checked = 0, cyc = 0;

	// One tick per ms keeps the long window at 200 low-power edges.
	windowed_watchdog_timer #(.LP_TICKS_PER_MS(16'h0001)) dut_u
	(
		.mclk               (mclk),
		.rst                (rst),
		.addr               (addr),
		.wdata              (wdata),
		.wr                 (wr),
		.rd                 (rd),
		.rdata              (rdata),
		.active_mode        (act),
		.debug_mode         (dbg),
		.low_power_clock    (lpc),
		.reset_req          (rreq),
		.sleep_req          (sreq),
		.watchdog_reset_flag(flag),
		.wdt_running        (run)
	);

	// The low-power clock is slower than 8 mclk and unrelated in phase.
	always #25 mclk = ~mclk;
	always #247 lpc = ~lpc;

	// A hang is cut short well above the expected run length.
	always @(posedge mclk)
	begin
		cyc++;
		if (cyc == 20000)
		begin
			err_count++;
			final_report;
		end
	end

	task automatic final_report;
		$display("checked %0d errors %0d", samples_checked, err_count);
		if (err_count == 0 && samples_checked > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	task automatic chk(string n, logic [31:0] e, logic [31:0] g);
		samples_checked++;
		if (g !== e)
		begin
			err_count++;
			$display("[FAIL] %s exp %h got %h", n, e, g);
		end
	endtask

	task automatic wr_t(logic [7:0] a, logic [31:0] d);
		@(posedge mclk);
		wr <= 1'b1;
		addr <= a;
		wdata <= d;
		@(posedge mclk);
		wr <= 1'b0;
	endtask

	// Read data stands only in the cycle after the strobe.
	task automatic rd_t(logic [7:0] a, logic [31:0] e, string n);
		@(posedge mclk);
		rd <= 1'b1;
		addr <= a;
		@(posedge mclk);
		rd <= 1'b0;
		#1 chk(n, e, rdata);
	endtask

	// Waits for a request pulse, then checks which kind it was.
	task automatic wait_p(logic slp);
		int i;
		for (i = 0; i < 2500; i++)
		begin
			#1;
			if (rreq | sreq)
				break;
			@(posedge mclk);
		end
		chk("sleep", {31'h0, slp}, {31'h0, sreq});
		chk("reset", {31'h0, !slp}, {31'h0, rreq});
		// Let the counted pulse pass so the next wait cannot see it again.
		@(posedge mclk);
	endtask

	initial
	begin
		repeat (10) @(posedge mclk);
		rst <= 1'b0;
		rd_t(8'h34, 32'h0, "trig");
		rd_t(8'h40, 32'h0, "unmapped");
		rd_t(8'h3c, 32'h20, "stat");
		wr_t(8'h34, 32'hffff_ff01);
		rd_t(8'h3c, 32'h40, "stat");
		rd_t(8'h34, 32'h01, "trig");
		wr_t(8'h34, 32'h01);
		wait_p(1'b0);
		#1 chk("flag", 32'h1, {31'h0, flag});
		rd_t(8'h38, 32'h1, "cause");
		rd_t(8'h3c, 32'h21, "stat");
		wr_t(8'h38, 32'h1);
		rd_t(8'h38, 32'h0, "cause");
		wr_t(8'h34, 32'h00);
		wait_p(1'b0);
		rd_t(8'h3c, 32'h22, "stat");
		wr_t(8'h34, 32'hc1);
		rd_t(8'h3c, 32'h40, "stat");
		repeat (120) @(posedge mclk);
		wr_t(8'h34, 32'hc0);
		rd_t(8'h3c, 32'h88, "stat");
		wr_t(8'h34, 32'hc1);
		rd_t(8'h3c, 32'h40, "stat");
		repeat (120) @(posedge mclk);
		wr_t(8'h34, 32'hc0);
		wr_t(8'h34, 32'hc0);
		wr_t(8'h34, 32'hc0);
		rd_t(8'h3c, 32'h98, "stat");
		wr_t(8'h34, 32'hc0);
		wait_p(1'b0);
		rd_t(8'h3c, 32'h21, "stat");
		// Short windows disabled: a code 00 in the open half must reset.
		wr_t(8'h34, 32'h01);
		repeat (120) @(posedge mclk);
		wr_t(8'h34, 32'h00);
		wait_p(1'b0);
		rd_t(8'h3c, 32'h21, "stat");
		repeat (3) wait_p(1'b0);
		wait_p(1'b1);
		repeat (3) @(posedge mclk);
		act <= 1'b0;
		#1 chk("run", 32'h0, {31'h0, run});
		repeat (2) @(posedge mclk);
		act <= 1'b1;
		rd_t(8'h3c, 32'h20, "stat");
		@(posedge mclk);
		dbg <= 1'b1;
		repeat (3) @(posedge mclk);
		#1 chk("run", 32'h0, {31'h0, run});
		final_report;
	end
endmodule
